// [design/ast_serial_sync.sv]
// converter control: serial port, sync, reset and data-ready timing
`timescale 1ns/1ps
`default_nettype none
// Contract
// - shift clock low over 64 data-ready falls resets the serial port
// - serial output changes only after each shift clock falling edge; here it also changes when data ready falls, to present the msb
// - serial input captured on shift clock rising edge; host keeps it stable
// - most significant bit is on the output when data ready falls
// - sync sampled on clock edges; host holds each phase two clocks
// - sync change acts at the clock edge that latches it; here the restart registers two edges after the first flop latches it
// - continuous sync aligned to the data period does not resynchronise
// - first data ready 62.98046875 periods plus 466 clocks after sync
// - reset low two clocks; data ready 62.98046875 periods plus 468 clocks after
// - after a read command new data follows within one data period
// - group delay 5 periods minimum phase, 31 periods linear phase
// - filter settles within 62 data periods for either phase response
// - sync restarts both digital filter and modulator
// - reset returns configuration to defaults and restarts conversion
module ast_serial_sync #(
   parameter int DATA_PERIOD = 4096,
   parameter int DR_SYNC_WAIT = (ast_pkg::DR_FRAC_NUM * DATA_PERIOD
      + ast_pkg::DR_FRAC_DEN - 1) / ast_pkg::DR_FRAC_DEN + ast_pkg::DR_SYNC_CLKS,
   parameter int DR_RESET_WAIT = (ast_pkg::DR_FRAC_NUM * DATA_PERIOD
      + ast_pkg::DR_FRAC_DEN - 1) / ast_pkg::DR_FRAC_DEN + ast_pkg::DR_RESET_CLKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pins from the host
   input wire logic sclk_pin,
   input wire logic din_pin,
   input wire logic sync_pin,
   input wire logic reset_n_pin,
   // control straps
   input wire ast_pkg::ast_ctl_t ctl,
   // filtered results from the decimator
   input wire logic result_valid,
   output logic result_ready,
   input wire logic [31:0] result_data,
   // pins to the host
   output logic dout,
   output logic data_ready_n,
   // conversion core control
   output logic filter_restart,
   output logic mod_restart,
   output logic cfg_defaults,
   output logic settled,
   output logic [5:0] group_delay,
   // received command bytes
   output logic [7:0] cmd_byte,
   output logic cmd_valid
);
   localparam int WAIT_W = $clog2(DR_RESET_WAIT + 1);
   localparam int PH_W = $clog2(DATA_PERIOD);

   // -------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------
   logic [3:0] meta;
   logic [3:0] sync_q;
   logic [3:0] prev_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         meta <= 4'h8;
         sync_q <= 4'h8;
         prev_q <= 4'h8;
      end else begin
         meta <= {reset_n_pin, sync_pin, din_pin, sclk_pin};
         sync_q <= meta;
         prev_q <= sync_q;
      end
   end
   wire sclk_s = sync_q[0];
   wire din_s = sync_q[1];
   wire sclk_rise = sync_q[0] & ~prev_q[0];
   wire sclk_fall = ~sync_q[0] & prev_q[0];
   // level change acts two edges after the first flop latches it, no async path
   wire sync_rise = sync_q[2] & ~prev_q[2];
   wire rst_low = ~sync_q[3];
   wire rst_release = sync_q[3] & ~prev_q[3];

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   ast_pkg::ast_state_t state, next_state;
   logic [WAIT_W-1:0] wait_cnt, next_wait_cnt;
   logic [PH_W-1:0] phase, next_phase;
   logic [5:0] settle_cnt, next_settle_cnt;
   logic [31:0] buf0, next_buf0, buf1, next_buf1;
   logic [1:0] buf_cnt, next_buf_cnt;
   logic [31:0] out_sh, next_out_sh;
   logic [7:0] in_sh, next_in_sh;
   logic [2:0] in_cnt, next_in_cnt;
   logic [6:0] idle_cnt, next_idle_cnt;
   logic read_pend, next_read_pend;
   logic next_result_ready, next_dout, next_data_ready_n;
   logic next_filter_restart, next_mod_restart, next_cfg_defaults;
   logic next_settled, next_cmd_valid;
   logic [5:0] next_group_delay;
   logic [7:0] next_cmd_byte;

   always_comb begin
      logic restart;
      logic tick;
      logic push;
      logic pop;
      logic load;
      logic [7:0] rx;
      restart = 1'b0;
      tick = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      load = 1'b0;
      rx = {in_sh[6:0], din_s};
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_phase = phase;
      next_settle_cnt = settle_cnt;
      next_buf0 = buf0;
      next_buf1 = buf1;
      next_buf_cnt = buf_cnt;
      next_out_sh = out_sh;
      next_in_sh = in_sh;
      next_in_cnt = in_cnt;
      next_idle_cnt = idle_cnt;
      next_read_pend = read_pend;
      next_dout = dout;
      next_data_ready_n = data_ready_n;
      next_filter_restart = 1'b0;
      next_mod_restart = 1'b0;
      next_cfg_defaults = 1'b0;
      next_settled = settled;
      next_cmd_valid = 1'b0;
      next_cmd_byte = cmd_byte;
      next_group_delay = ctl.linear_phase ? ast_pkg::GRP_DELAY_LIN
                                          : ast_pkg::GRP_DELAY_MIN;

      // data period divider; the phase names the conversion frame
      if (phase == PH_W'(DATA_PERIOD - 1)) begin
         next_phase = '0;
         tick = (state == ast_pkg::ST_RUN);
      end else begin
         next_phase = phase + 1'b1;
      end

      // run state: frame ticks count the settling periods
      if (tick && settle_cnt != ast_pkg::SETTLE_PERIODS) begin
         next_settle_cnt = settle_cnt + 1'b1;
      end
      if (tick && settle_cnt == ast_pkg::SETTLE_PERIODS - 6'h01) begin
         next_settled = 1'b1;
      end

      // wait state: hold data ready high until the wait count runs out
      if (state == ast_pkg::ST_WAIT) begin
         if (wait_cnt != '0) begin
            next_wait_cnt = wait_cnt - 1'b1;
         end
         if (wait_cnt == WAIT_W'(1)) begin
            next_state = ast_pkg::ST_RUN;
            next_phase = '0;
            tick = 1'b1;
         end
      end

      // two-entry result buffer; drained once per frame so data stays fresh
      pop = tick && buf_cnt != 2'h0;
      push = result_valid && result_ready;
      load = pop && (ctl.read_cont || read_pend);
      if (pop) begin
         next_buf0 = buf1;
         next_buf_cnt = buf_cnt - 2'h1;
      end
      if (push) begin
         if (next_buf_cnt == 2'h0) begin
            next_buf0 = result_data;
         end else begin
            next_buf1 = result_data;
         end
         next_buf_cnt = next_buf_cnt + 2'h1;
      end

      // shift out: msb ready before any shift edge, then advance on falls
      if (load) begin
         next_out_sh = buf0;
         next_dout = buf0[31];
         next_data_ready_n = 1'b0;
         next_read_pend = 1'b0;
      end else if (sclk_fall) begin
         next_out_sh = {out_sh[30:0], 1'b0};
         next_dout = out_sh[30];
         next_data_ready_n = 1'b1;
      end

      // command receive on rising edges
      if (sclk_rise) begin
         next_in_sh = rx;
         next_in_cnt = in_cnt + 3'h1;
         if (in_cnt == 3'h7) begin
            next_cmd_byte = rx;
            next_cmd_valid = 1'b1;
            if (rx == ast_pkg::CMD_READ_DATA) begin
               next_read_pend = 1'b1;
            end
         end
      end

      // idle reset: count data-ready falls while the shift clock stays low
      if (sclk_s) begin
         next_idle_cnt = 7'h00;
      end else if (load) begin
         next_idle_cnt = idle_cnt + 7'h01;
         if (idle_cnt == ast_pkg::IDLE_RESET_EDGES - 7'h01) begin
            next_idle_cnt = 7'h00;
            next_in_cnt = 3'h0;
            next_in_sh = 8'h00;
            next_read_pend = 1'b0;
         end
      end

      // pulse sync always restarts; continuous sync only when off-frame
      if (sync_rise && !(ctl.cont_sync && phase == (state == ast_pkg::ST_RUN ?
            PH_W'(DATA_PERIOD - 1 - DR_SYNC_WAIT % DATA_PERIOD) : PH_W'(DATA_PERIOD - 1)))) begin
         restart = 1'b1;
         next_wait_cnt = WAIT_W'(DR_SYNC_WAIT);
      end
      if (rst_low || rst_release) begin
         restart = 1'b1;
         next_wait_cnt = WAIT_W'(DR_RESET_WAIT);
         next_cfg_defaults = rst_low;
         next_in_cnt = 3'h0;
         next_read_pend = 1'b0;
      end
      if (restart) begin
         next_state = ast_pkg::ST_WAIT;
         next_phase = '0;
         next_settle_cnt = 6'h00;
         next_settled = 1'b0;
         next_buf_cnt = 2'h0;
         next_data_ready_n = 1'b1;
         next_filter_restart = 1'b1;
         next_mod_restart = 1'b1;
      end
      next_result_ready = next_buf_cnt != 2'h2;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ast_pkg::ST_WAIT;
         wait_cnt <= WAIT_W'(DR_RESET_WAIT);
         phase <= '0;
         settle_cnt <= 6'h00;
         buf0 <= 32'h0000_0000;
         buf1 <= 32'h0000_0000;
         buf_cnt <= 2'h0;
         out_sh <= 32'h0000_0000;
         in_sh <= 8'h00;
         in_cnt <= 3'h0;
         idle_cnt <= 7'h00;
         read_pend <= 1'b0;
         result_ready <= 1'b0;
         dout <= 1'b0;
         data_ready_n <= 1'b1;
         filter_restart <= 1'b0;
         mod_restart <= 1'b0;
         cfg_defaults <= 1'b1;
         settled <= 1'b0;
         group_delay <= ast_pkg::GRP_DELAY_MIN;
         cmd_byte <= 8'h00;
         cmd_valid <= 1'b0;
      end else begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         phase <= next_phase;
         settle_cnt <= next_settle_cnt;
         buf0 <= next_buf0;
         buf1 <= next_buf1;
         buf_cnt <= next_buf_cnt;
         out_sh <= next_out_sh;
         in_sh <= next_in_sh;
         in_cnt <= next_in_cnt;
         idle_cnt <= next_idle_cnt;
         read_pend <= next_read_pend;
         result_ready <= next_result_ready;
         dout <= next_dout;
         data_ready_n <= next_data_ready_n;
         filter_restart <= next_filter_restart;
         mod_restart <= next_mod_restart;
         cfg_defaults <= next_cfg_defaults;
         settled <= next_settled;
         group_delay <= next_group_delay;
         cmd_byte <= next_cmd_byte;
         cmd_valid <= next_cmd_valid;
      end
   end
endmodule
`default_nettype wire

// [include/ast_pkg.sv]
// shared constants and types for the converter serial and sync timing block
package ast_pkg;
   // data-ready delay = 62.98046875 data periods + fixed clocks; 62.98046875 = 16123/256
   localparam int DR_FRAC_NUM = 16123;
   localparam int DR_FRAC_DEN = 256;
   localparam int DR_SYNC_CLKS = 466;
   localparam int DR_RESET_CLKS = 468;
   // serial port idle reset: data-ready falling edges with shift clock low
   localparam logic [6:0] IDLE_RESET_EDGES = 7'h40;
   // filter group delay and settling, in data periods
   localparam logic [5:0] GRP_DELAY_MIN = 6'h05;
   localparam logic [5:0] GRP_DELAY_LIN = 6'h1f;
   localparam logic [5:0] SETTLE_PERIODS = 6'h3e;
   localparam int WORD_BITS = 32;
   localparam int CMD_BITS = 8;
   // command code that requests one conversion word; value is arbitrary
   localparam logic [7:0] CMD_READ_DATA = 8'h10;

   typedef enum logic [0:0] {
      ST_WAIT = 1'b0,
      ST_RUN = 1'b1
   } ast_state_t;

   typedef struct packed {
      logic cont_sync;
      logic linear_phase;
      logic read_cont;
   } ast_ctl_t;
endpackage

// [sim/ast_host_model.sv]
// behavioural host that clocks the serial port
`timescale 1ns/1ps
`default_nettype none
module ast_host_model #(
   parameter int HALF_NS = 16
) (
   // request
   input wire logic go,
   input wire logic [7:0] tx,
   input wire logic [5:0] nbits,
   // serial pins
   input wire logic dout,
   output logic sclk,
   output logic din,
   // result
   output logic [31:0] rx,
   output logic busy
);
   initial begin
      sclk = 1'b0;
      din = 1'b1;
      rx = 32'h0000_0000;
      busy = 1'b0;
   end
   // clock stands low between transfers; din idles at the inverse of its last bit
   always @(posedge go) begin
      busy = 1'b1;
      #3;
      for (int i = 0; i < int'(nbits); i++) begin
         din = (i < 8) ? tx[7 - i] : 1'b0;
         #(HALF_NS);
         sclk = 1'b1;
         #(HALF_NS);
         rx = {rx[30:0], dout};
         sclk = 1'b0;
      end
      #(HALF_NS);
      din = ~din;
      busy = 1'b0;
   end
endmodule
`default_nettype wire

// [sim/ast_serial_sync_bench.sv]
// self-checking bench for the serial, sync and reset timing block
`timescale 1ns/1ps
`default_nettype none
module ast_serial_sync_bench;
   localparam int P = 512;
   localparam int WS = 100;
   localparam int WR = 102;
   localparam logic [31:0] WORD = 32'hc35a_0f69;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sync_pin = 1'b0;
   logic reset_n_pin = 1'b1;
   logic result_valid = 1'b1;
   ast_pkg::ast_ctl_t ctl = '{cont_sync: 1'b0, linear_phase: 1'b0, read_cont: 1'b1};
   logic go = 1'b0;
   logic [7:0] tx = 8'h00;
   logic [5:0] nbits = 6'h20;
   logic sclk, din, dout, data_ready_n, result_ready, cmd_valid, busy, cfg_defaults;
   logic [7:0] cmd_byte, last_cmd;
   logic [31:0] rx;
   logic [5:0] group_delay;
   logic settled, filt_restart;
   int mismatches = 0;
   int samples_checked = 0;
   int n;
   always #2 clk = ~clk;
   ast_serial_sync #(.DATA_PERIOD(P), .DR_SYNC_WAIT(WS), .DR_RESET_WAIT(WR)) dut (
      .clk(clk), .srst(srst), .sclk_pin(sclk), .din_pin(din), .sync_pin(sync_pin),
      .reset_n_pin(reset_n_pin), .ctl(ctl), .result_valid(result_valid),
      .result_ready(result_ready), .result_data(WORD), .dout(dout),
      .data_ready_n(data_ready_n), .filter_restart(filt_restart), .mod_restart(),
      .cfg_defaults(cfg_defaults), .settled(settled), .group_delay(group_delay),
      .cmd_byte(cmd_byte), .cmd_valid(cmd_valid));
   ast_host_model host (.go(go), .tx(tx), .nbits(nbits), .dout(dout), .sclk(sclk),
      .din(din), .rx(rx), .busy(busy));
   always @(posedge clk) if (cmd_valid === 1'b1) last_cmd <= cmd_byte;
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wait_dr(output int cnt);
      cnt = 0;
      while (data_ready_n !== 1'b0 && cnt < 2 * P) begin
         @(posedge clk);
         cnt++;
      end
   endtask
   task automatic xfer(input logic [7:0] b, input logic [5:0] k);
      int t;
      t = 0;
      tx <= b;
      nbits <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy === 1'b1 && t < 600) begin
         @(posedge clk);
         t++;
      end
      repeat (24) @(posedge clk);
   endtask
   task automatic sync_pulse(input int gap, output int hits);
      hits = 0;
      repeat (gap) @(posedge clk);
      sync_pin <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         if (i == 5) sync_pin <= 1'b0;
         if (filt_restart === 1'b1) hits++;
      end
   endtask
   task automatic t_cont;
      int h;
      sync_pulse(0, h);
      check("pulse sync restarts", 32'h1, 32'(h));
      ctl.cont_sync <= 1'b1;
      sync_pulse(P - 12, h);
      check("aligned sync ignored", 32'h0, 32'(h));
      sync_pulse(P - 5, h);
      check("unaligned sync restarts", 32'h1, 32'(h));
      ctl.cont_sync <= 1'b0;
   endtask
   task automatic t_idle;
      check("settled early", 32'h0, 32'(settled));
      xfer(ast_pkg::CMD_READ_DATA, 6'h04);
      repeat (66 * P) @(posedge clk);
      check("settled late", 32'h1, 32'(settled));
      xfer(ast_pkg::CMD_READ_DATA, 6'h08);
      check("byte after idle reset", 32'(ast_pkg::CMD_READ_DATA), 32'(last_cmd));
   endtask
   task automatic t_boot;
      wait_dr(n);
      check("boot delay", 32'h1, 32'(n >= WR - 1 && n <= WR + 4));
      xfer(8'h00, 6'h20);
      check("first word", WORD, rx);
   endtask
   task automatic t_gdelay;
      for (int i = 0; i < 2; i++) begin
         ctl.linear_phase <= i[0];
         repeat (4) @(posedge clk);
         check("group delay", 32'(i ? ast_pkg::GRP_DELAY_LIN : ast_pkg::GRP_DELAY_MIN),
            32'(group_delay));
      end
   endtask
   task automatic t_sync;
      sync_pin <= 1'b1;
      repeat (6) @(posedge clk);
      sync_pin <= 1'b0;
      check("held after sync", 32'h1, 32'(data_ready_n));
      wait_dr(n);
      check("sync delay", 32'h1, 32'(n + 6 >= WS + 2 && n + 6 <= WS + 7));
      xfer(8'h00, 6'h20);
      check("word after sync", WORD, rx);
   endtask
   task automatic t_cmd;
      ctl.read_cont <= 1'b0;
      xfer(8'h00, 6'h20);
      repeat (2 * P) @(posedge clk);
      check("idle without command", 32'h1, 32'(data_ready_n));
      xfer(ast_pkg::CMD_READ_DATA, 6'h08);
      check("command byte", 32'(ast_pkg::CMD_READ_DATA), 32'(last_cmd));
      wait_dr(n);
      check("command latency", 32'h1, 32'(n <= P + 8));
      xfer(8'h00, 6'h20);
      check("word after command", WORD, rx);
      ctl.read_cont <= 1'b1;
   endtask
   task automatic t_buf;
      n = 0;
      repeat (P) begin
         @(posedge clk);
         if (result_ready === 1'b0) n++;
      end
      check("buffer refuses", 32'h1, 32'(n > 0));
      result_valid <= 1'b0;
      repeat (3 * P) @(posedge clk);
      check("buffer drained", 32'h1, 32'(result_ready));
      result_valid <= 1'b1;
   endtask
   task automatic t_rst_pin;
      reset_n_pin <= 1'b0;
      repeat (8) @(posedge clk);
      check("defaults in reset", 32'h1, 32'(cfg_defaults));
      check("held in reset", 32'h1, 32'(data_ready_n));
      reset_n_pin <= 1'b1;
      wait_dr(n);
      check("reset delay", 32'h1, 32'(n >= WR + 1 && n <= WR + 7));
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_boot();
      t_gdelay();
      t_sync();
      t_cont();
      t_cmd();
      t_buf();
      t_idle();
      t_rst_pin();
      end_sim();
   end
   initial begin
      #250000;
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire

// [sim/ast_serial_sync_monitor.sv]
// checker for the serial, sync and reset timing block
`timescale 1ns/1ps
`default_nettype none
module ast_serial_sync_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pins and straps
   input wire logic sclk_pin,
   input wire logic sync_pin,
   input wire logic reset_n_pin,
   input wire ast_pkg::ast_ctl_t ctl,
   // outputs
   input wire logic dout,
   input wire logic data_ready_n,
   input wire logic filter_restart,
   input wire logic mod_restart,
   input wire logic cfg_defaults,
   input wire logic [5:0] group_delay,
   input wire logic cmd_valid
);
   logic sclk_q;
   logic [3:0] since_rise;
   logic [3:0] since_fall;
   logic next_sclk_q;
   logic [3:0] next_since_rise;
   logic [3:0] next_since_fall;
   // saturating ages of the last raw shift clock edges
   always_comb begin
      next_sclk_q = sclk_pin;
      next_since_rise = since_rise + ((since_rise != 4'hf) ? 4'h1 : 4'h0);
      next_since_fall = since_fall + ((since_fall != 4'hf) ? 4'h1 : 4'h0);
      if (srst || (sclk_pin && !sclk_q)) next_since_rise = srst ? 4'hf : 4'h0;
      if (srst || (!sclk_pin && sclk_q)) next_since_fall = srst ? 4'hf : 4'h0;
   end
   always_ff @(posedge clk) begin
      sclk_q <= next_sclk_q;
      since_rise <= next_since_rise;
      since_fall <= next_since_fall;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_sync_edge;
      !ctl.cont_sync && $rose(sync_pin) ##1 sync_pin;
   endsequence
   sequence s_rst_low;
      !reset_n_pin [*6];
   endsequence
   a_sync_restart: assert property (s_sync_edge |-> ##[1:4] filter_restart)
      else $error("sync edge gave no restart");
   a_restart_pair: assert property (filter_restart == mod_restart)
      else $error("filter and modulator restarts differ");
   a_dr_quiet: assert property (filter_restart |-> data_ready_n [*8])
      else $error("data ready asserted right after restart");
   a_rst_defaults: assert property (s_rst_low |-> cfg_defaults && data_ready_n)
      else $error("reset pin low without defaults");
   a_grp_delay: assert property (!$past(srst) && $stable(ctl.linear_phase) |->
      group_delay == (ctl.linear_phase ? ast_pkg::GRP_DELAY_LIN : ast_pkg::GRP_DELAY_MIN))
      else $error("group delay wrong");
   a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
      else $error("command strobe longer than one cycle");
   a_cmd_cause: assert property (cmd_valid |-> since_rise <= 4'h7)
      else $error("command strobe without shift clock rise");
   a_dout_cause: assert property ($changed(dout) |-> $fell(data_ready_n)
      || since_fall <= 4'h7 || filter_restart || $past(filter_restart))
      else $error("serial output changed without a falling shift edge");
endmodule
bind ast_serial_sync ast_serial_sync_monitor u_mon (.clk(clk), .srst(srst),
   .sclk_pin(sclk_pin), .sync_pin(sync_pin), .reset_n_pin(reset_n_pin), .ctl(ctl),
   .dout(dout), .data_ready_n(data_ready_n), .filter_restart(filter_restart),
   .mod_restart(mod_restart), .cfg_defaults(cfg_defaults), .group_delay(group_delay),
   .cmd_valid(cmd_valid));
`default_nettype wire
